// [rtl/usc_pkg.sv]
package usc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_TX_FIFO_FLUSH  = 8'h4E;
  localparam logic [7:0] ADDR_SYSTEM_CONTROL = 8'h4F;
  localparam logic [7:0] ADDR_SETUP_FIRST    = 8'hD0;
  localparam logic [7:0] ADDR_SETUP_LAST     = 8'hD7;

  // ****************************************
  // Fields
  // ****************************************
  localparam int         FLUSH_EP_LSB      = 1;
  localparam int         NUM_TX_EP         = 3;
  localparam int         SOFT_RESET_BIT    = 0;
  localparam logic [3:0] OSC_STOP_PATTERN  = 4'hA;
  localparam int         REQ_DIR_BIT       = 7;
  localparam int         REQ_TYPE_MSB      = 6;
  localparam int         REQ_TYPE_LSB      = 5;
  localparam int         REQ_RECIP_MSB     = 4;
  localparam int         REQ_RECIP_LSB     = 0;
  localparam int         SETUP_BYTES       = 8;

  // ****************************************
  // Reset and read values
  // ****************************************
  localparam logic [7:0] SETUP_RESET_VALUE = 8'h00;
  localparam logic [7:0] WO_READ_VALUE     = 8'h00;
  localparam logic [7:0] UNMAPPED_VALUE    = 8'h00;

endpackage

// [rtl/usc_tx_ep.sv]
`timescale 1ns/10ps
`default_nettype none

// One transmit endpoint: flush strobe and packet-ready flag
module usc_tx_ep (
  input  wire logic clk_i,        // Core clock
  input  wire logic rst_i,        // Combined reset, active high
  input  wire logic tx_dir_i,     // Endpoint configured to transmit
  input  wire logic flush_req_i,  // Flush bit written as one
  input  wire logic ready_set_i,  // Software sets packet ready
  input  wire logic ack_i,        // Host ACK of IN data
  output logic      flush_o,      // One-cycle FIFO flush pulse
  output logic      ready_o,      // Packet ready flag
  output logic      nak_o         // Answer IN tokens with NAK
);

  logic do_flush;

  assign do_flush = flush_req_i & tx_dir_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flush_o <= 1'b0;
    end else begin
      flush_o <= do_flush;
    end
  end

  // A set in the flush cycle survives; the later write is honoured
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_o <= 1'b0;
    end else if (ready_set_i) begin
      ready_o <= 1'b1;
    end else if (do_flush || ack_i) begin
      ready_o <= 1'b0;
    end
  end

  assign nak_o = ~ready_o;

endmodule // usc_tx_ep

`default_nettype wire

// [rtl/usc_top.sv]
`timescale 1ns/10ps
`default_nettype none

module usc_top (
  input  wire logic       CORE_CLK_I,        // 250 MHz core clock
  input  wire logic       RSTN_I,            // Hardware reset, active low
  input  wire logic       CS_N_I,            // Chip select, active low
  input  wire logic       RD_N_I,            // Read strobe, active low
  input  wire logic       WR_N_I,            // Write strobe, active low
  input  wire logic [7:0] ADDR_I,            // Register address
  input  wire logic [7:0] DATA_I,            // Data bus input
  output logic      [7:0] DATA_O,            // Data bus output
  output logic            DATA_OE_O,         // Data bus drive enable
  input  wire logic       USB_BUS_RESET_I,   // USB bus reset level
  input  wire logic       SETUP_START_I,     // Setup stage begins
  input  wire logic       SETUP_VALID_I,     // Setup byte strobe
  input  wire logic [7:0] SETUP_BYTE_I,      // Setup byte from host
  input  wire logic [3:1] EP_TX_DIR_I,       // Endpoint set to transmit
  input  wire logic [3:1] READY_SET_I,       // Set packet ready
  input  wire logic [3:1] EP_ACK_I,          // Host ACK per endpoint
  output logic      [3:1] TX_FLUSH_O,        // FIFO flush pulses
  output logic      [3:1] PACKET_READY_O,    // Packet ready flags
  output logic      [3:1] IN_NAK_O,          // NAK IN tokens
  output logic            SOFT_RESET_O,      // Device-wide reset pulse
  output logic            OSC_STOP_O,        // Oscillator stopped
  output logic            FIFO_ACCESS_EN_O,  // FIFO access serviced
  output logic            REQ_DIR_O,         // Captured direction
  output logic      [1:0] REQ_TYPE_O,        // Captured request type
  output logic      [4:0] REQ_RECIP_O        // Captured recipient
);

  // ****************************************
  // Reset and bus strobes
  // ****************************************
  logic       soft_rst;
  logic       dev_rst;
  logic       wr_n_q;
  logic       wr_pulse;
  logic       rd_act;
  logic       wr_flush;
  logic       wr_sysctl;
  logic [3:1] flush_sel;
  logic       soft_rst_cmd;
  logic       osc_stop_cmd;
  logic       cap_rst;
  logic       capture_en;
  logic [3:0] next_setup_idx;
  logic       rd_setup;
  logic [7:0] setup_bytes [usc_pkg::SETUP_BYTES];
  logic [3:0] setup_idx;
  logic [2:0] rd_idx;
  logic [7:0] next_rdata;

  assign dev_rst  = ~RSTN_I | soft_rst;
  assign rd_act   = ~CS_N_I & ~RD_N_I;
  assign wr_pulse = ~CS_N_I & ~WR_N_I & wr_n_q;
  assign wr_flush  = wr_pulse && (ADDR_I == usc_pkg::ADDR_TX_FIFO_FLUSH);
  assign wr_sysctl = wr_pulse && (ADDR_I == usc_pkg::ADDR_SYSTEM_CONTROL);

  // Edge detect so a long write strobe acts only once, except a soft-reset write: dev_rst reloads wr_n_q, so it fires again
  always_ff @(posedge CORE_CLK_I) begin
    if (dev_rst) begin
      wr_n_q <= 1'b1;
    end else begin
      wr_n_q <= WR_N_I | CS_N_I;
    end
  end

  // ****************************************
  // Write decode
  // ****************************************
  // Only these fields reach any logic; all other bits fall away
  assign flush_sel    =
    DATA_I[usc_pkg::FLUSH_EP_LSB +: usc_pkg::NUM_TX_EP];
  assign soft_rst_cmd =
    wr_sysctl & DATA_I[usc_pkg::SOFT_RESET_BIT];
  assign osc_stop_cmd =
    wr_sysctl && (DATA_I[7:4] == usc_pkg::OSC_STOP_PATTERN);

  // ****************************************
  // System control
  // ****************************************
  // Held by hardware reset only, so the pulse ends on its own
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= soft_rst_cmd;
    end
  end

  assign SOFT_RESET_O = soft_rst;

  // Standby is only reported; gating the oscillator lives outside
  // A stop command written together with the reset bit sets OSC_STOP_O for one cycle; the soft reset then clears it
  always_ff @(posedge CORE_CLK_I) begin
    if (dev_rst) begin
      OSC_STOP_O <= 1'b0;
    end else if (osc_stop_cmd) begin
      OSC_STOP_O <= 1'b1;
    end
  end

  // Register path keeps running in standby; only FIFOs are fenced off
  assign FIFO_ACCESS_EN_O = ~OSC_STOP_O;

  // ****************************************
  // Transmit endpoints 1..3
  // ****************************************
  // Flush bits of receive endpoints are dropped inside each endpoint
  for (genvar ep = 1; ep <= usc_pkg::NUM_TX_EP; ep++) begin : g_ep
    usc_tx_ep u_ep (
      .clk_i       (CORE_CLK_I),
      .rst_i       (dev_rst),
      .tx_dir_i    (EP_TX_DIR_I[ep]),
      .flush_req_i (wr_flush & flush_sel[ep]),
      .ready_set_i (READY_SET_I[ep]),
      .ack_i       (EP_ACK_I[ep]),
      .flush_o     (TX_FLUSH_O[ep]),
      .ready_o     (PACKET_READY_O[ep]),
      .nak_o       (IN_NAK_O[ep])
    );
  end

  // ****************************************
  // Setup packet capture
  // ****************************************
  // Bus reset clears the capture but leaves the endpoints alone
  assign cap_rst    = dev_rst | USB_BUS_RESET_I;
  // Bytes past the eighth are dropped until the next setup stage
  assign capture_en = SETUP_VALID_I && !SETUP_START_I &&
                      (setup_idx < 4'(usc_pkg::SETUP_BYTES));

  always_comb begin
    next_setup_idx = setup_idx;
    if (SETUP_START_I) begin
      next_setup_idx = 4'h0;
    end else if (capture_en) begin
      next_setup_idx = setup_idx + 4'h1;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (cap_rst) begin
      setup_idx <= 4'h0;
    end else begin
      setup_idx <= next_setup_idx;
    end
  end

  // Bytes stored as received, byte n at D0h+n
  always_ff @(posedge CORE_CLK_I) begin
    if (cap_rst) begin
      for (int i = 0; i < usc_pkg::SETUP_BYTES; i++) begin
        setup_bytes[i] <= usc_pkg::SETUP_RESET_VALUE;
      end
    end else if (capture_en) begin
      setup_bytes[setup_idx[2:0]] <= SETUP_BYTE_I;
    end
  end

  assign REQ_DIR_O   = setup_bytes[0][usc_pkg::REQ_DIR_BIT];
  assign REQ_TYPE_O  =
    setup_bytes[0][usc_pkg::REQ_TYPE_MSB:usc_pkg::REQ_TYPE_LSB];
  assign REQ_RECIP_O =
    setup_bytes[0][usc_pkg::REQ_RECIP_MSB:usc_pkg::REQ_RECIP_LSB];

  // ****************************************
  // Read path
  // ****************************************
  assign rd_idx   = ADDR_I[2:0];
  assign rd_setup = (ADDR_I >= usc_pkg::ADDR_SETUP_FIRST) &&
                    (ADDR_I <= usc_pkg::ADDR_SETUP_LAST);

  // Write-only addresses answer a fixed value; software must not use it
  always_comb begin
    next_rdata = usc_pkg::UNMAPPED_VALUE;
    case (ADDR_I)
      usc_pkg::ADDR_TX_FIFO_FLUSH,
      usc_pkg::ADDR_SYSTEM_CONTROL: begin
        next_rdata = usc_pkg::WO_READ_VALUE;
      end
      default: begin
        if (rd_setup) begin
          next_rdata = setup_bytes[rd_idx];
        end
      end
    endcase
  end

  // Registered so read data stands a whole cycle after the address
  always_ff @(posedge CORE_CLK_I) begin
    if (dev_rst) begin
      DATA_O <= 8'h00;
    end else begin
      DATA_O <= next_rdata;
    end
  end

  // Drive enable follows the strobes directly, so the bus frees at once
  assign DATA_OE_O = rd_act;

endmodule // usc_top

`default_nettype wire

// [tb/usc_properties.sv]
`timescale 1ns/10ps
`default_nettype none
// ********
// Checker
// ********
module usc_properties (
  input wire logic       CORE_CLK_I,       // Clock
  input wire logic       RSTN_I,           // Reset
  input wire logic       CS_N_I,           // Select
  input wire logic       WR_N_I,           // Write
  input wire logic [7:0] ADDR_I,           // Address
  input wire logic [7:0] DATA_I,           // Write data
  input wire logic [3:1] EP_TX_DIR_I,      // Transmit set
  input wire logic [3:1] READY_SET_I,      // Ready set
  input wire logic [3:1] TX_FLUSH_O,       // Flush
  input wire logic [3:1] PACKET_READY_O,   // Ready
  input wire logic [3:1] IN_NAK_O,         // NAK
  input wire logic       SOFT_RESET_O,     // Soft reset
  input wire logic       OSC_STOP_O,       // Standby
  input wire logic       FIFO_ACCESS_EN_O  // FIFO enable
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);
  // Write taken only on the first low edge of the strobe pair
  sequence s_wr(logic [7:0] a);
    !CS_N_I && !WR_N_I && ($past(CS_N_I) || $past(WR_N_I)) && ADDR_I == a;
  endsequence
  AST_FLUSH: assert property (s_wr(8'h4E) |=>
    TX_FLUSH_O == $past(DATA_I[3:1] & EP_TX_DIR_I))
    else $error("flush pulses wrong");
  AST_FLUSH_ONLY: assert property (|TX_FLUSH_O |->
    $past(!CS_N_I && !WR_N_I && ADDR_I == 8'h4E))
    else $error("flush without write");
  AST_READY_DROP: assert property (s_wr(8'h4E) |=>
    !(|(PACKET_READY_O & $past(DATA_I[3:1] & EP_TX_DIR_I & ~READY_SET_I))))
    else $error("ready kept after flush");
  AST_NAK: assert property (IN_NAK_O == ~PACKET_READY_O)
    else $error("nak differs from ready");
  // Pulse for one cycle, then the device shows its reset state
  sequence s_soft_done;
    SOFT_RESET_O ##1 (!SOFT_RESET_O && !OSC_STOP_O && PACKET_READY_O == 3'h0);
  endsequence
  AST_SOFT: assert property (s_wr(8'h4F) ##0 DATA_I[0] |=>
    s_soft_done)
    else $error("soft reset wrong");
  AST_OSC_STOP: assert property (s_wr(8'h4F) ##0
    DATA_I[7:4] == 4'hA && !DATA_I[0] |=> OSC_STOP_O)
    else $error("standby not entered");
  // Hardware reset ends standby too; the fall shows just after release
  AST_OSC_HOLD: assert property ($fell(OSC_STOP_O) |->
    SOFT_RESET_O || $past(SOFT_RESET_O) || !$past(RSTN_I))
    else $error("standby left without reset");
  AST_FIFO_EN: assert property (FIFO_ACCESS_EN_O == !OSC_STOP_O)
    else $error("fifo enable wrong");
  AST_NO_SIDE: assert property (s_wr(8'h4F) ##0
    DATA_I[7:4] != 4'hA && !DATA_I[0] |=> !SOFT_RESET_O && $stable(OSC_STOP_O))
    else $error("side effect on plain write");
endmodule // usc_properties
bind usc_top usc_properties u_props (.CORE_CLK_I, .RSTN_I, .CS_N_I,
  .WR_N_I, .ADDR_I, .DATA_I, .EP_TX_DIR_I, .READY_SET_I, .TX_FLUSH_O,
  .PACKET_READY_O, .IN_NAK_O, .SOFT_RESET_O, .OSC_STOP_O, .FIFO_ACCESS_EN_O);
`default_nettype wire

// [tb/usc_host.sv]
`timescale 1ns/10ps
`default_nettype none
// ********
// Host sending setup stages
// ********
module usc_host (
  input  wire logic       clk_i,    // Clock
  output logic            start_o,  // Setup begins
  output logic            valid_o,  // Byte strobe
  output logic      [7:0] byte_o    // Setup byte
);
  initial begin
    start_o = 1'b0;
    valid_o = 1'b0;
    byte_o = 8'h00;
  end
  // Gap models a slow host; byte lines toggle in gap cycles but hold in the start cycle
  task automatic send(input logic [63:0] pkt, input int gap);
    @(negedge clk_i) start_o = 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_i) start_o = 1'b0;
      valid_o = 1'b1;
      byte_o = pkt[63-8*i -: 8];
      repeat (gap) begin
        @(negedge clk_i) valid_o = 1'b0;
        byte_o = ~byte_o;
      end
    end
    @(negedge clk_i) valid_o = 1'b0;
    byte_o = ~byte_o;
  endtask
endmodule // usc_host
`default_nettype wire

// [tb/usc_top_bench.sv]
`timescale 1ns/10ps
`default_nettype none
// ********
// Bench
// ********
module usc_top_bench;
  logic        clk, rstn, cs_n, rd_n, wr_n, oe, bus_rst, start, valid;
  logic        sres, osc, fen, rdir;
  logic  [7:0] addr, din, dout, sbyte;
  logic  [3:1] dir, rset, ack, flush, rdy, nak;
  logic  [1:0] rtype;
  logic  [4:0] recip;
  logic [63:0] pk [5] = '{64'h8006_0001_0000_1200, 64'h21FE_3412_7856_BC9A,
                          64'hC201_0203_0405_0607, 64'h63FF_00FF_00FF_00FF,
                          64'h1F80_4020_1008_0402};
  int          n_fail = 0, cmp_count = 0, cyc = 0;
  usc_top dut (.CORE_CLK_I(clk), .RSTN_I(rstn), .CS_N_I(cs_n), .RD_N_I(rd_n),
    .WR_N_I(wr_n), .ADDR_I(addr), .DATA_I(din), .DATA_O(dout),
    .DATA_OE_O(oe), .USB_BUS_RESET_I(bus_rst), .SETUP_START_I(start),
    .SETUP_VALID_I(valid), .SETUP_BYTE_I(sbyte), .EP_TX_DIR_I(dir),
    .READY_SET_I(rset), .EP_ACK_I(ack), .TX_FLUSH_O(flush),
    .PACKET_READY_O(rdy), .IN_NAK_O(nak), .SOFT_RESET_O(sres),
    .OSC_STOP_O(osc), .FIFO_ACCESS_EN_O(fen), .REQ_DIR_O(rdir),
    .REQ_TYPE_O(rtype), .REQ_RECIP_O(recip));
  usc_host host (.clk_i(clk), .start_o(start), .valid_o(valid),
    .byte_o(sbyte));
  task automatic chk(input string nm, input logic [7:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk) {cs_n, wr_n, addr, din} = {2'b00, a, d};
    @(negedge clk) {cs_n, wr_n} = 2'b11;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(negedge clk) {cs_n, rd_n, addr} = {2'b00, a};
    @(posedge clk) #1 chk("read data", e, dout);
    chk("read oe", 8'h01, {7'h0, oe});
    @(negedge clk) {cs_n, rd_n} = 2'b11;
  endtask
  task automatic give_verdict;
    $display("TB: %0d checks, %0d mismatches", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    {rstn, cs_n, rd_n, wr_n, bus_rst} = 5'b01110;
    {addr, din, dir, rset, ack} = '0;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    for (int i = 0; i < 8; i++) rd(8'hD0 + 8'(i), 8'h00);
    rd(usc_pkg::ADDR_TX_FIFO_FLUSH, usc_pkg::WO_READ_VALUE);
    rd(usc_pkg::ADDR_SYSTEM_CONTROL, usc_pkg::WO_READ_VALUE);
    chk("nak rst", 8'h07, {5'h0, nak});
    chk("fifo en rst", 8'h01, {7'h0, fen});
    $display("TB: reset test done");
    for (int k = 0; k < 5; k++) begin
      host.send(pk[k], k);
      for (int i = 0; i < 8; i++) rd(8'hD0 + 8'(i), pk[k][63-8*i -: 8]);
      chk("dir", {7'h0, pk[k][63]}, {7'h0, rdir});
      chk("type", {6'h0, pk[k][62:61]}, {6'h0, rtype});
      chk("recip", {3'h0, pk[k][60:56]}, {3'h0, recip});
    end
    @(negedge clk) bus_rst = 1'b1;
    @(negedge clk) bus_rst = 1'b0;
    for (int i = 0; i < 8; i++) rd(8'hD0 + 8'(i), 8'h00);
    $display("TB: setup test done");
    dir = 3'b101;
    @(negedge clk) rset = 3'b111;
    @(negedge clk) rset = 3'b000;
    wr(usc_pkg::ADDR_TX_FIFO_FLUSH, 8'hFF);
    chk("flush", 8'h05, {5'h0, flush});
    chk("ready", 8'h02, {5'h0, rdy});
    @(negedge clk) ack = 3'b010;
    @(negedge clk) ack = 3'b000;
    chk("nak", 8'h07, {5'h0, nak});
    $display("TB: flush test done");
    wr(usc_pkg::ADDR_SYSTEM_CONTROL, 8'hA0);
    chk("osc", 8'h01, {7'h0, osc});
    chk("fifo en", 8'h00, {7'h0, fen});
    host.send(pk[1], 0);
    rd(8'hD0, pk[1][63:56]);
    wr(usc_pkg::ADDR_SYSTEM_CONTROL, 8'h5E);
    chk("osc", 8'h01, {7'h0, osc});
    wr(usc_pkg::ADDR_SYSTEM_CONTROL, 8'hA1);
    chk("soft rst", 8'h01, {7'h0, sres});
    rd(8'hD0, 8'h00);
    chk("osc", 8'h00, {7'h0, osc});
    chk("fifo en", 8'h01, {7'h0, fen});
    @(negedge clk) bus_rst = 1'b1;
    @(negedge clk) bus_rst = 1'b0;
    host.send(pk[2], 0);
    for (int i = 0; i < 8; i++) rd(8'hD0 + 8'(i), pk[2][63-8*i -: 8]);
    wr(usc_pkg::ADDR_SYSTEM_CONTROL, 8'hA0);
    @(negedge clk) rstn = 1'b0;
    @(negedge clk) rstn = 1'b1;
    chk("osc", 8'h00, {7'h0, osc});
    $display("TB: standby test done");
    give_verdict();
  end
endmodule // usc_top_bench
`default_nettype wire
